// [src/pin_function_select.sv]
/*
 * Function selector for nine shared port pins with its AHB-Lite register slave.
 * Assumes a single-master AHB-Lite bus on clock; pads are resolved outside from out/oe.
 */
`timescale 1ns/100ps
module pin_function_select (
	input wire logic clock,
	input wire logic rstn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Pads
	input wire logic [8:0] pad_in,
	output logic [8:0] pad_out,
	output logic [8:0] pad_oe,
	// Port logic
	input wire logic [8:0] gpio_out,
	input wire logic [8:0] gpio_oe,
	output logic [8:0] gpio_in,
	// Analog converter channel switches, ch0..ch4
	output logic [4:0] analog_in_connect,
	// Advanced timer
	input wire logic timer_cmp_out_a,
	input wire logic timer_cmp_oe_a,
	output logic timer_capture_in_a,
	input wire logic timer_cmp_out_b,
	input wire logic timer_cmp_oe_b,
	output logic timer_capture_in_b,
	// Clock generator
	input wire logic clock_gen_output_first,
	input wire logic clock_gen_output_second,
	output logic fast_oscillator_connect,
	output logic ext_fast_clock_in,
	output logic slow_oscillator_connect,
	// Debug unit
	input wire logic debug_status_out,
	input wire logic debug_serial_out,
	input wire logic debug_serial_oe,
	output logic debug_serial_in
);
	localparam int unsigned NP = pin_mux_pkg::NUM_PINS;

	// ========================================================================
	// AHB-Lite address phase capture
	// ========================================================================
	logic wr_pend_q;
	logic [31:0] wr_addr_q;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic hresp_q;
	logic addr_take;

	logic [7:0] port2_upper_q;
	logic [7:0] port3_lower_q;
	logic [1:0] port3_bit4_q;

	// Never waits: every transfer finishes in its first data-phase cycle
	assign addr_take = hsel & hready & htrans[pin_mux_pkg::HTRANS_ACTIVE_BIT];

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 32'h0000_0000;
		end else if (hready) begin
			wr_pend_q <= addr_take & hwrite;
			wr_addr_q <= haddr;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hreadyout_q <= 1'b1;
			hresp_q <= pin_mux_pkg::RESP_OKAY;
		end else begin
			hreadyout_q <= 1'b1;
			hresp_q <= pin_mux_pkg::RESP_OKAY;
		end
	end

	// ========================================================================
	// Register writes in the data phase
	// ========================================================================
	logic wr_p2;
	logic wr_p3;
	logic wr_p34;

	assign wr_p2 = wr_pend_q & (wr_addr_q == pin_mux_pkg::ADDR_PORT2_UPPER);
	assign wr_p3 = wr_pend_q & (wr_addr_q == pin_mux_pkg::ADDR_PORT3_LOWER);
	assign wr_p34 = wr_pend_q & (wr_addr_q == pin_mux_pkg::ADDR_PORT3_BIT4);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			port2_upper_q <= pin_mux_pkg::RST_PORT2_UPPER;
		end else if (wr_p2) begin
			port2_upper_q <= hwdata[pin_mux_pkg::REG_W-1:0];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			port3_lower_q <= pin_mux_pkg::RST_PORT3_LOWER;
		end else if (wr_p3) begin
			port3_lower_q <= hwdata[pin_mux_pkg::REG_W-1:0];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			port3_bit4_q <= pin_mux_pkg::RST_PORT3_BIT4;
		end else if (wr_p34) begin
			// Only the field is stored; upper write bits are dropped
			port3_bit4_q <= hwdata[pin_mux_pkg::FLD_W-1:0];
		end
	end

	// ========================================================================
	// Read data, registered at the address phase
	// ========================================================================
	// A write in its data phase is forwarded so a following read sees it
	logic [7:0] p2_view;
	logic [7:0] p3_view;
	logic [1:0] p34_view;
	logic [31:0] rd_mux;

	assign p2_view = wr_p2 ? hwdata[pin_mux_pkg::REG_W-1:0] : port2_upper_q;
	assign p3_view = wr_p3 ? hwdata[pin_mux_pkg::REG_W-1:0] : port3_lower_q;
	assign p34_view = wr_p34 ? hwdata[pin_mux_pkg::FLD_W-1:0] : port3_bit4_q;

	always_comb begin
		rd_mux = pin_mux_pkg::READ_UNMAPPED;
		if (haddr == pin_mux_pkg::ADDR_PORT2_UPPER) begin
			rd_mux = {24'h00_0000, p2_view};
		end else if (haddr == pin_mux_pkg::ADDR_PORT3_LOWER) begin
			rd_mux = {24'h00_0000, p3_view};
		end else if (haddr == pin_mux_pkg::ADDR_PORT3_BIT4) begin
			rd_mux = {30'h0000_0000, p34_view};
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (addr_take & ~hwrite) begin
			hrdata_q <= rd_mux;
		end
	end

	// ========================================================================
	// Field decode
	// ========================================================================
	logic [1:0] sel_pin_2_4;
	logic [1:0] sel_pin_2_5;
	logic [1:0] sel_pin_2_6;
	logic [1:0] sel_pin_2_7;
	logic [1:0] sel_pin_3_0;
	logic [1:0] sel_pin_3_1;
	logic [1:0] sel_pin_3_2;
	logic [1:0] sel_pin_3_3;
	logic [1:0] sel_pin_3_4;

	assign sel_pin_2_7 = port2_upper_q[pin_mux_pkg::FLD_HI +: pin_mux_pkg::FLD_W];
	assign sel_pin_2_6 = port2_upper_q[pin_mux_pkg::FLD_MH +: pin_mux_pkg::FLD_W];
	assign sel_pin_2_5 = port2_upper_q[pin_mux_pkg::FLD_ML +: pin_mux_pkg::FLD_W];
	assign sel_pin_2_4 = port2_upper_q[pin_mux_pkg::FLD_LO +: pin_mux_pkg::FLD_W];
	assign sel_pin_3_3 = port3_lower_q[pin_mux_pkg::FLD_HI +: pin_mux_pkg::FLD_W];
	assign sel_pin_3_2 = port3_lower_q[pin_mux_pkg::FLD_MH +: pin_mux_pkg::FLD_W];
	assign sel_pin_3_1 = port3_lower_q[pin_mux_pkg::FLD_ML +: pin_mux_pkg::FLD_W];
	assign sel_pin_3_0 = port3_lower_q[pin_mux_pkg::FLD_LO +: pin_mux_pkg::FLD_W];
	assign sel_pin_3_4 = port3_bit4_q;

	// ========================================================================
	// Port logic ownership
	// ========================================================================
	logic [NP-1:0] gpio_sel;

	assign gpio_sel[pin_mux_pkg::PIN_2_4] = sel_pin_2_4 == pin_mux_pkg::SEL_GPIO;
	assign gpio_sel[pin_mux_pkg::PIN_2_5] = sel_pin_2_5 == pin_mux_pkg::SEL_GPIO;
	assign gpio_sel[pin_mux_pkg::PIN_2_6] = sel_pin_2_6 == pin_mux_pkg::SEL_GPIO;
	assign gpio_sel[pin_mux_pkg::PIN_2_7] = sel_pin_2_7 == pin_mux_pkg::SEL_GPIO;
	assign gpio_sel[pin_mux_pkg::PIN_3_0] = sel_pin_3_0 == pin_mux_pkg::SEL_GPIO;
	assign gpio_sel[pin_mux_pkg::PIN_3_1] = sel_pin_3_1 == pin_mux_pkg::SEL_DBG_GPIO;
	assign gpio_sel[pin_mux_pkg::PIN_3_2] = sel_pin_3_2 == pin_mux_pkg::SEL_DBG_GPIO;
	assign gpio_sel[pin_mux_pkg::PIN_3_3] = sel_pin_3_3 == pin_mux_pkg::SEL_GPIO;
	assign gpio_sel[pin_mux_pkg::PIN_3_4] = sel_pin_3_4 == pin_mux_pkg::SEL_GPIO;

	// ========================================================================
	// Pad drive selection
	// ========================================================================
	// Reserved and analog/oscillator codes leave the pad undriven
	logic [NP-1:0] drive_d;
	logic [NP-1:0] enable_d;

	always_comb begin
		drive_d = gpio_out & gpio_sel;
		enable_d = gpio_oe & gpio_sel;
		if (sel_pin_2_4 == pin_mux_pkg::SEL_ALT2) begin
			drive_d[pin_mux_pkg::PIN_2_4] = clock_gen_output_first;
			enable_d[pin_mux_pkg::PIN_2_4] = 1'b1;
		end
		if (sel_pin_2_5 == pin_mux_pkg::SEL_ALT2) begin
			drive_d[pin_mux_pkg::PIN_2_5] = clock_gen_output_second;
			enable_d[pin_mux_pkg::PIN_2_5] = 1'b1;
		end
		if (sel_pin_2_6 == pin_mux_pkg::SEL_ALT2) begin
			drive_d[pin_mux_pkg::PIN_2_6] = timer_cmp_out_a;
			enable_d[pin_mux_pkg::PIN_2_6] = timer_cmp_oe_a;
		end
		if (sel_pin_2_7 == pin_mux_pkg::SEL_ALT2) begin
			drive_d[pin_mux_pkg::PIN_2_7] = timer_cmp_out_b;
			enable_d[pin_mux_pkg::PIN_2_7] = timer_cmp_oe_b;
		end
		if (sel_pin_3_1 == pin_mux_pkg::SEL_DBG_FUNC) begin
			drive_d[pin_mux_pkg::PIN_3_1] = debug_serial_out;
			enable_d[pin_mux_pkg::PIN_3_1] = debug_serial_oe;
		end
		if (sel_pin_3_2 == pin_mux_pkg::SEL_DBG_FUNC) begin
			drive_d[pin_mux_pkg::PIN_3_2] = debug_status_out;
			enable_d[pin_mux_pkg::PIN_3_2] = 1'b1;
		end
	end

	pad_drive_stage #(
		.W(NP)
	) u_drive (
		.clock(clock),
		.rstn(rstn),
		.drive_d(drive_d),
		.enable_d(enable_d),
		.pad_out_q(pad_out),
		.pad_oe_q(pad_oe)
	);

	// ========================================================================
	// Pad input sampling and return paths
	// ========================================================================
	logic [NP-1:0] pad_level;

	pin_sync3 #(
		.W(NP)
	) u_sync (
		.clock(clock),
		.rstn(rstn),
		.async_in(pad_in),
		.level_q(pad_level)
	);

	logic [NP-1:0] gpio_in_q;
	logic timer_cap_a_q;
	logic timer_cap_b_q;
	logic ext_fast_q;
	logic debug_serial_in_q;

	// Unselected receivers see the idle level, never the pad
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			gpio_in_q <= '0;
		end else begin
			gpio_in_q <= pad_level & gpio_sel;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			timer_cap_a_q <= pin_mux_pkg::IDLE_LEVEL;
			timer_cap_b_q <= pin_mux_pkg::IDLE_LEVEL;
		end else begin
			timer_cap_a_q <= (sel_pin_2_6 == pin_mux_pkg::SEL_ALT2) ? pad_level[pin_mux_pkg::PIN_2_6]
				: pin_mux_pkg::IDLE_LEVEL;
			timer_cap_b_q <= (sel_pin_2_7 == pin_mux_pkg::SEL_ALT2) ? pad_level[pin_mux_pkg::PIN_2_7]
				: pin_mux_pkg::IDLE_LEVEL;
		end
	end

	// External clock is sampled like any pad; good only well below clock/4
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ext_fast_q <= pin_mux_pkg::IDLE_LEVEL;
		end else begin
			ext_fast_q <= (sel_pin_3_3 == pin_mux_pkg::SEL_ALT2) ? pad_level[pin_mux_pkg::PIN_3_3]
				: pin_mux_pkg::IDLE_LEVEL;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			debug_serial_in_q <= pin_mux_pkg::IDLE_LEVEL;
		end else begin
			debug_serial_in_q <= (sel_pin_3_1 == pin_mux_pkg::SEL_DBG_FUNC) ? pad_level[pin_mux_pkg::PIN_3_1]
				: pin_mux_pkg::IDLE_LEVEL;
		end
	end

	// ========================================================================
	// Analog and oscillator switch enables
	// ========================================================================
	logic [pin_mux_pkg::NUM_ANALOG-1:0] analog_q;
	logic fast_osc_q;
	logic slow_osc_q;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			analog_q <= '0;
		end else begin
			analog_q[0] <= sel_pin_3_0 == pin_mux_pkg::SEL_ALT1;
			analog_q[1] <= sel_pin_2_7 == pin_mux_pkg::SEL_ALT1;
			analog_q[2] <= sel_pin_2_6 == pin_mux_pkg::SEL_ALT1;
			analog_q[3] <= sel_pin_2_5 == pin_mux_pkg::SEL_ALT1;
			analog_q[4] <= sel_pin_2_4 == pin_mux_pkg::SEL_ALT1;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fast_osc_q <= 1'b0;
			slow_osc_q <= 1'b0;
		end else begin
			fast_osc_q <= sel_pin_3_3 == pin_mux_pkg::SEL_ALT1;
			slow_osc_q <= sel_pin_3_4 == pin_mux_pkg::SEL_ALT1;
		end
	end

	// ========================================================================
	// Output assignments
	// ========================================================================
	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign gpio_in = gpio_in_q;
	assign analog_in_connect = analog_q;
	assign timer_capture_in_a = timer_cap_a_q;
	assign timer_capture_in_b = timer_cap_b_q;
	assign fast_oscillator_connect = fast_osc_q;
	assign ext_fast_clock_in = ext_fast_q;
	assign slow_oscillator_connect = slow_osc_q;
	assign debug_serial_in = debug_serial_in_q;
endmodule : pin_function_select

// [src/pin_mux_pkg.sv]
/*
 * Constants for the shared-pin function selector of port pins P24..P27, P30..P34.
 * Assumes a 32-bit AHB-Lite register bus, one clock and an asynchronous active-low reset.
 */
// Function
// - Field 7:6 of port2_upper picks P27: port, analog ch1, timer channel B.
// - Field 5:4 of port2_upper picks P26: port, analog ch2, timer channel A.
// - Field 3:2 of port2_upper picks P25: port, analog ch3, clock output second.
// - Field 1:0 of port2_upper picks P24: port, analog ch4, clock output first.
// - Each pin connects only to its selected function; others neither drive nor see it.
// - Field 7:6 of port3_lower picks P33: port, fast oscillator, external fast clock.
// - Field 5:4 of port3_lower picks P32: debug status (reset default) or port.
// - Field 3:2 of port3_lower picks P31: debug serial line (reset default) or port.
// - Field 1:0 of port3_lower picks P30: port (default) or analog ch0.
// - Field 1:0 of port3_bit4 picks P34: port or slow oscillator; bits 7:2 read zero.
package pin_mux_pkg;
	// ========================================================================
	// Register indices and byte addresses
	// ========================================================================
	localparam int unsigned IDX_PORT2_UPPER = 32'h0000_52a5;
	localparam int unsigned IDX_PORT3_LOWER = 32'h0000_52a6;
	localparam int unsigned IDX_PORT3_BIT4 = 32'h0000_52a7;
	localparam logic [31:0] ADDR_PORT2_UPPER = 32'(IDX_PORT2_UPPER * 4);
	localparam logic [31:0] ADDR_PORT3_LOWER = 32'(IDX_PORT3_LOWER * 4);
	localparam logic [31:0] ADDR_PORT3_BIT4 = 32'(IDX_PORT3_BIT4 * 4);

	// ========================================================================
	// Field layout, codes and reset values
	// ========================================================================
	localparam int unsigned REG_W = 8;
	localparam int unsigned FLD_W = 2;
	localparam int unsigned FLD_HI = 6;
	localparam int unsigned FLD_MH = 4;
	localparam int unsigned FLD_ML = 2;
	localparam int unsigned FLD_LO = 0;
	localparam logic [1:0] SEL_GPIO = 2'h0;
	localparam logic [1:0] SEL_ALT1 = 2'h1;
	localparam logic [1:0] SEL_ALT2 = 2'h2;
	localparam logic [1:0] SEL_DBG_FUNC = 2'h0;
	localparam logic [1:0] SEL_DBG_GPIO = 2'h1;
	localparam logic [7:0] RST_PORT2_UPPER = 8'h00;
	localparam logic [7:0] RST_PORT3_LOWER = 8'h00;
	localparam logic [1:0] RST_PORT3_BIT4 = 2'h0;

	// ========================================================================
	// Pin numbering on the pad vectors
	// ========================================================================
	localparam int unsigned NUM_PINS = 9;
	localparam int unsigned NUM_ANALOG = 5;
	localparam int unsigned PIN_2_4 = 0;
	localparam int unsigned PIN_2_5 = 1;
	localparam int unsigned PIN_2_6 = 2;
	localparam int unsigned PIN_2_7 = 3;
	localparam int unsigned PIN_3_0 = 4;
	localparam int unsigned PIN_3_1 = 5;
	localparam int unsigned PIN_3_2 = 6;
	localparam int unsigned PIN_3_3 = 7;
	localparam int unsigned PIN_3_4 = 8;

	// ========================================================================
	// Bus encodings
	// ========================================================================
	localparam int unsigned HTRANS_ACTIVE_BIT = 1;
	localparam logic RESP_OKAY = 1'b0;
	localparam logic IDLE_LEVEL = 1'b0;
	localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
endpackage : pin_mux_pkg

// [src/pin_sync3.sv]
/*
 * Three-stage pin synchroniser with agreement filter, one per bit.
 * Assumes inputs asynchronous to clock; output is registered.
 */
`timescale 1ns/100ps
module pin_sync3 #(
	parameter int unsigned W = 9
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] level_q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					s1_q[i] <= 1'b0;
					s2_q[i] <= 1'b0;
					s3_q[i] <= 1'b0;
					level_q[i] <= 1'b0;
				end else begin
					s1_q[i] <= async_in[i];
					s2_q[i] <= s1_q[i];
					s3_q[i] <= s2_q[i];
					// Second and third stage must agree before a change counts
					if (s2_q[i] == s3_q[i]) begin
						level_q[i] <= s3_q[i];
					end
				end
			end
		end
	endgenerate
endmodule : pin_sync3

// [src/pad_drive_stage.sv]
/*
 * Registered pad driver: one output and enable flop per pin.
 * Assumes drive values come from the function selector on the same clock.
 */
`timescale 1ns/100ps
module pad_drive_stage #(
	parameter int unsigned W = 9
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [W-1:0] drive_d,
	input wire logic [W-1:0] enable_d,
	output logic [W-1:0] pad_out_q,
	output logic [W-1:0] pad_oe_q
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_pad
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					pad_out_q[i] <= 1'b0;
					pad_oe_q[i] <= 1'b0;
				end else begin
					// Data is forced low whenever the pin is not driven
					pad_out_q[i] <= drive_d[i] & enable_d[i];
					pad_oe_q[i] <= enable_d[i];
				end
			end
		end
	endgenerate
endmodule : pad_drive_stage

// [dv/pin_mux_sva.sv]
/*
 * Checker for the shared-pin function selector: bus answer and pad ownership.
 * Bound to the ports of pin_function_select; one clock, asynchronous active-low reset.
 */
`timescale 1ns/100ps
module pin_mux_sva (
	input logic clock,
	input logic rstn,
	input logic hreadyout,
	input logic hresp,
	input logic [8:0] pad_out,
	input logic [8:0] pad_oe,
	input logic [8:0] gpio_out,
	input logic [8:0] gpio_oe,
	input logic [8:0] gpio_in,
	input logic [4:0] analog_in_connect,
	input logic timer_cmp_oe_b,
	input logic timer_capture_in_b,
	input logic fast_oscillator_connect,
	input logic slow_oscillator_connect,
	input logic ext_fast_clock_in,
	input logic debug_serial_oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// ========================================================================
	// Bus answer and released pads
	// ========================================================================
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus slave not ready or not okay");
	a_undriven_low: assert property ((pad_out & ~pad_oe) == 9'h000)
		else $error("pad data set while pad released");
	// ========================================================================
	// One owner per pin
	// ========================================================================
	// Channel k sits on pin index 4-k, so the pin vectors are reversed before masking
	a_analog_floats: assert property (analog_in_connect != 5'h00 |->
		(analog_in_connect & {pad_oe[0], pad_oe[1], pad_oe[2], pad_oe[3], pad_oe[4]}) == 5'h00 &&
		(analog_in_connect & {gpio_in[0], gpio_in[1], gpio_in[2], gpio_in[3], gpio_in[4]}) == 5'h00)
		else $error("analog pin still driven or seen by port");
	a_fast_osc_alone: assert property (fast_oscillator_connect |-> !pad_oe[7] && !gpio_in[7])
		else $error("fast oscillator pin not released");
	a_slow_osc_alone: assert property (slow_oscillator_connect |-> !pad_oe[8] && !gpio_in[8])
		else $error("slow oscillator pin not released");
	a_extclk_owner: assert property (ext_fast_clock_in |-> !gpio_in[7] && !fast_oscillator_connect)
		else $error("external clock pin shared");
	a_capture_owner: assert property (timer_capture_in_b |-> !gpio_in[3] && !analog_in_connect[1])
		else $error("capture pin shared");
	// Pins with no output function beside the port: only the port may drive them
	a_port_only_drive: assert property ((pad_oe & 9'h190 & ~$past(gpio_oe)) == 9'h000 &&
		((pad_out ^ $past(gpio_out)) & pad_oe & 9'h190) == 9'h000)
		else $error("port-only pin driven by another source");
	a_p27_drivers: assert property (pad_oe[3] |-> $past(gpio_oe[3] || timer_cmp_oe_b))
		else $error("pin 2_7 driven without an enabled owner");
	a_p31_drivers: assert property (pad_oe[5] |-> $past(gpio_oe[5] || debug_serial_oe))
		else $error("pin 3_1 driven without an enabled owner");
endmodule : pin_mux_sva

// [dv/pad_world.sv]
/*
 * Model of the external pads: resolves each pin from the block and an outside driver.
 * Assumes the outside driver is never enabled against a pin the block drives.
 */
`timescale 1ns/100ps
module pad_world (
	input logic clock,
	input logic [8:0] pad_out,
	input logic [8:0] pad_oe,
	input logic [8:0] ext_en,
	input logic [8:0] ext_val,
	output logic [8:0] pad_in
);
	logic [8:0] float_q = 9'h0aa;
	// A released pin toggles every cycle, so a cut-off receiver cannot match by luck
	always @(posedge clock) float_q <= ~float_q;
	always_comb begin
		for (int i = 0; i < 9; i++) begin
			pad_in[i] = pad_oe[i] ? pad_out[i] : (ext_en[i] ? ext_val[i] : float_q[i]);
		end
	end
endmodule : pad_world

// [dv/port_function_select_p24_p34_bench.sv]
/*
 * Self-checking bench for the shared-pin function selector over AHB-Lite.
 * Assumes pin_mux_pkg, pin_function_select, pad_world and pin_mux_sva are compiled first.
 */
`timescale 1ns/100ps
module port_function_select_p24_p34_bench;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic hreadyout, hresp;
	logic [8:0] pad_in, pad_out, pad_oe, gpio_in;
	logic [8:0] ext_en = 9'h000;
	logic g = 1'b0;
	logic oe_on = 1'b1;
	logic [4:0] analog_in_connect;
	logic timer_capture_in_a, timer_capture_in_b, fast_oscillator_connect;
	logic slow_oscillator_connect, ext_fast_clock_in, debug_serial_in;
	int num_errors = 0;
	int n_checks = 0;
	int unsigned cycles = 0;
	logic [31:0] r;
	logic [31:0] a [3] = '{pin_mux_pkg::ADDR_PORT2_UPPER, pin_mux_pkg::ADDR_PORT3_LOWER, pin_mux_pkg::ADDR_PORT3_BIT4};
	// Per setting: field byte, pads driven, pads owned by port, analog switches, other receivers
	logic [7:0] t_reg [4] = '{8'h00, 8'h55, 8'haa, 8'hff};
	logic [8:0] t_oe [4] = '{9'h1ff, 9'h060, 9'h00f, 9'h000};
	// Pads still driven with every enable input low: debug status, clock generator outputs
	logic [8:0] t_on [4] = '{9'h040, 9'h000, 9'h003, 9'h000};
	logic [8:0] t_gm [4] = '{9'h19f, 9'h060, 9'h000, 9'h000};
	logic [4:0] t_an [4] = '{5'h00, 5'h1f, 5'h00, 5'h00};
	logic [5:0] t_misc [4] = '{6'h01, 6'h30, 6'h0e, 6'h00};
	logic [8:0] oe_x;

	always #4 clock = ~clock;

	pin_function_select pin_function_select_inst (.clock, .rstn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pad_in, .pad_out, .pad_oe,
		.gpio_out({9{g}}), .gpio_oe({9{oe_on}}), .gpio_in, .analog_in_connect,
		.timer_cmp_out_a(~g), .timer_cmp_oe_a(oe_on), .timer_capture_in_a,
		.timer_cmp_out_b(~g), .timer_cmp_oe_b(oe_on), .timer_capture_in_b,
		.clock_gen_output_first(~g), .clock_gen_output_second(~g), .fast_oscillator_connect,
		.ext_fast_clock_in, .slow_oscillator_connect, .debug_status_out(~g),
		.debug_serial_out(~g), .debug_serial_oe(oe_on), .debug_serial_in);

	pad_world pad_world_inst (.clock, .pad_out, .pad_oe, .ext_en, .ext_val(9'h1ff), .pad_in);

	// ========================================================================
	// Bus access and comparison
	// ========================================================================
	task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= ad;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			wrap_up();
		end
	end

	// ========================================================================
	// Tests
	// ========================================================================
	initial begin
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		for (int k = 0; k < 3; k++) begin
			bus(1'b0, a[k], 32'h0, r);
			chk(r, 32'h0);
			bus(1'b1, a[k], 32'hffff_ffff, r);
			bus(1'b0, a[k], 32'h0, r);
			chk(r, (k == 2) ? 32'h3 : 32'hff);
		end
		bus(1'b1, a[2] + 32'h4, 32'hffff_ffff, r);
		bus(1'b0, a[2] + 32'h4, 32'h0, r);
		chk(r, 32'h0);
		// Each setting is run with port data low, high, and with all enables off
		for (int i = 0; i < 4; i++) begin
			for (int p = 0; p < 3; p++) begin
				g <= p[0];
				oe_on <= (p != 2);
				ext_en <= (i == 2) ? 9'h080 : 9'h000;
				bus(1'b1, a[0], {24'h0, t_reg[i]}, r);
				bus(1'b1, a[1], {24'h0, t_reg[i]}, r);
				bus(1'b1, a[2], {30'h0, i[1:0]}, r);
				bus(1'b0, a[1], 32'h0, r);
				chk(r, {24'h0, t_reg[i]});
				repeat (8) @(posedge clock);
				oe_x = oe_on ? t_oe[i] : t_on[i];
				chk(32'(pad_oe), 32'(oe_x));
				chk(32'(pad_out), 32'(oe_x & (({9{g}} & t_gm[i]) | ({9{~g}} & ~t_gm[i]))));
				chk(32'(analog_in_connect), 32'(t_an[i]));
				if (oe_on) begin
					chk(32'(gpio_in), 32'(t_gm[i] & {9{g}}));
					chk(32'({fast_oscillator_connect, slow_oscillator_connect, ext_fast_clock_in,
						timer_capture_in_a, timer_capture_in_b, debug_serial_in}),
						32'(t_misc[i] & {3'h7, {3{~g}}}));
				end
			end
		end
		rstn <= 1'b0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		bus(1'b0, a[0], 32'h0, r);
		chk(r, 32'h0);
		wrap_up();
	end
endmodule : port_function_select_p24_p34_bench

bind pin_function_select pin_mux_sva pin_mux_sva_inst (.clock, .rstn, .hreadyout, .hresp, .pad_out,
	.pad_oe, .gpio_out, .gpio_oe, .gpio_in, .analog_in_connect, .timer_cmp_oe_b, .timer_capture_in_b,
	.fast_oscillator_connect, .slow_oscillator_connect, .ext_fast_clock_in, .debug_serial_oe);
